// ==== rtl/frf_pkg.sv ====
// Purpose: Shared constants and types of the function request facility.
// Assumes: Register port with byte addresses, 32-bit words, aligned.
// Notes: Offsets below are the word-aligned byte addresses of each field.
package frf_pkg;

   localparam int FRF_AW = 8;
   localparam int FRF_DW = 32;
   localparam int FRF_NUM_OPERANDS = 7;
   localparam int FRF_NUM_WINDOWS = 4;
   localparam int FRF_NUM_SEGS = 4;

   // Request area and facility offsets.
   localparam logic [7:0] FRF_OFF_OPCODE = 8'h00;
   localparam logic [7:0] FRF_OFF_PROC_INDEX = 8'h04;
   localparam logic [7:0] FRF_OFF_FUNC_STATE = 8'h08;
   localparam logic [7:0] FRF_OFF_CONTROL = 8'h0c;
   localparam logic [7:0] FRF_OFF_RESULT = 8'h10;
   localparam logic [7:0] FRF_OFF_FAULT_INFO = 8'h14;
   localparam logic [7:0] FRF_OFF_OPERAND = 8'h20;
   localparam logic [7:0] FRF_OFF_WINMAP = 8'h40;
   localparam logic [7:0] FRF_OFF_WIN4MAP = 8'h50;
   localparam logic [7:0] FRF_OFF_SEGDESC = 8'h60;

   // Control register fields.
   localparam int FRF_CTL_SUPPRESS_OK = 0;
   localparam int FRF_CTL_PHYSICAL = 1;
   localparam logic [1:0] FRF_CTL_RESET = 2'h0;

   // Function state layout: completion at [1:0], window busy at bit 4.
   localparam int FRF_FS_WIN_BUSY = 4;
   localparam logic [1:0] FRF_CS_READY = 2'h0;
   localparam logic [1:0] FRF_CS_BUSY = 2'h1;
   localparam logic [1:0] FRF_CS_OK = 2'h2;
   localparam logic [1:0] FRF_CS_FAULT = 2'h3;

   // Segment descriptor fields: limit [13:0], read right 14, valid type 15.
   localparam int FRF_SD_RIGHT = 14;
   localparam int FRF_SD_TYPE = 15;

   // Opcodes.
   localparam logic [7:0] FRF_OP_READ_STATUS = 8'h01;
   localparam logic [7:0] FRF_OP_WINDOW_REMAP = 8'h02;
   localparam logic [7:0] FRF_OP_TEST_OBJECT = 8'h03;
   localparam logic [7:0] FRF_OP_SET_MODE = 8'h04;
   localparam logic [7:0] FRF_BOOL_TRUE = 8'h01;
   localparam logic [2:0] FRF_CONTROL_WINDOW = 3'h4;

   // Fault codes.
   localparam logic [7:0] FRF_FC_OPCODE = 8'h01;
   localparam logic [7:0] FRF_FC_PROCESS = 8'h02;
   localparam logic [7:0] FRF_FC_TYPE = 8'h03;
   localparam logic [7:0] FRF_FC_RIGHTS = 8'h04;
   localparam logic [7:0] FRF_FC_BOUNDS = 8'h05;
   localparam logic [7:0] FRF_FC_REMAP = 8'h06;

   typedef enum logic [2:0] {
      FRF_ST_IDLE,
      FRF_ST_QUALIFY,
      FRF_ST_DECODE,
      FRF_ST_FETCH,
      FRF_ST_OPERATE,
      FRF_ST_UPDATE,
      FRF_ST_RESULT,
      FRF_ST_FINISH
   } frf_state_t;

   typedef struct packed {
      frf_state_t st;
      logic [7:0] opcode;
      logic [15:0] proc_index;
      logic [FRF_NUM_OPERANDS-1:0][15:0] operand;
      logic [FRF_NUM_OPERANDS-1:0][15:0] work;
      logic [2:0] fetch_idx;
      logic [2:0] need;
      logic [1:0] compl;
      logic win_busy;
      logic fault;
      logic [7:0] fault_code;
      logic [15:0] fault_info;
      logic [1:0] control;
      logic [31:0] result;
      logic [FRF_NUM_WINDOWS-1:0][15:0] winmap;
      logic [15:0] win4map;
      logic [FRF_NUM_SEGS-1:0][15:0] segdesc;
      logic [15:0] clock;
      logic proc_lock;
      logic irq;
      logic [31:0] rdata;
   } frf_regs_t;

   // Operand count implied by each opcode.
   function automatic logic [2:0] frf_operand_count(input logic [7:0] op);
      logic [2:0] n;
      n = 3'h0;
      if (op == FRF_OP_WINDOW_REMAP)
      begin
         n = 3'h2;
      end
      else if (op == FRF_OP_TEST_OBJECT || op == FRF_OP_SET_MODE)
      begin
         n = 3'h1;
      end
      return n;
   endfunction : frf_operand_count

endpackage : frf_pkg

// ==== rtl/frf_request_facility.sv ====
// Purpose: Function request facility reached through the control window.
// Assumes: Synchronous inputs; controller issues one function at a time.
// Notes: All state lives in one packed struct registered once per clock.
// Functional notes
// - Each completion updates facility status and raises an interrupt.
// - A setting suppresses interrupts for successful completions only.
// - In logical mode the control window mapping never changes.
// - Functions start only from the control window; others carry data.
// - Completion state shows readiness for a new request.
// - Writing the opcode starts execution; operands must be placed first.
// - One-byte unique opcode implies how many operands are fetched.
// - Zero to seven sixteen-bit operands read from the operands field.
// - Operands are counts, bit fields or object selectors.
// - Selector low part picks access segment, high part indexes within.
// - Selector resolution checks type, rights and bounds, faulting.
// - Opcode write makes the device qualify and lock the process.
// - Control window shows in-progress during execution.
// - Decode, fetch operands, operate, update destinations, write return.
// - End by updating completion state and interrupting; check faults.
// - Completion state tells success from fault.
// - A fault records additional fault information.
// - Request accesses may interleave freely with other bus traffic.
// - Return value low byte sits at the lowest result location.
// - Boolean return is one byte, low bit one for true.
// - Fault leaves results undefined; no return value leaves them unchanged.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps

module frf_request_facility
   import frf_pkg::*;
#(
   parameter int NUM_PROCS = 8
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [FRF_AW-1:0] reg_addr,
   input wire logic [FRF_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [FRF_DW-1:0] reg_rdata,
   output logic irq_req
);

   frf_regs_t r_reg;
   frf_regs_t r_next;
   logic [31:0] rd_val;
   logic [15:0] sel;
   logic [15:0] desc;

   assign reg_rdata = r_reg.rdata;
   assign irq_req = r_reg.irq;

   // Selector split: segment number low, index within the segment high.
   assign sel = r_reg.work[0];
   assign desc = r_reg.segdesc[sel[1:0]];

   // Read mux; unmapped addresses answer zero.
   always_comb
   begin
      case (reg_addr)
         FRF_OFF_OPCODE: rd_val = {24'h0, r_reg.opcode};
         FRF_OFF_PROC_INDEX: rd_val = {16'h0, r_reg.proc_index};
         FRF_OFF_FUNC_STATE: rd_val = {27'h0, r_reg.win_busy, 2'h0,
            r_reg.compl};
         FRF_OFF_CONTROL: rd_val = {30'h0, r_reg.control};
         FRF_OFF_RESULT: rd_val = r_reg.result;
         FRF_OFF_FAULT_INFO: rd_val = {16'h0, r_reg.fault_info};
         FRF_OFF_WIN4MAP: rd_val = {16'h0, r_reg.win4map};
         default: rd_val = 32'h0;
      endcase
      for (int i = 0; i < FRF_NUM_OPERANDS; i++)
      begin
         if (reg_addr == FRF_OFF_OPERAND + 8'(4 * i))
         begin
            rd_val = {16'h0, r_reg.operand[i]};
         end
      end
      for (int i = 0; i < FRF_NUM_WINDOWS; i++)
      begin
         if (reg_addr == FRF_OFF_WINMAP + 8'(4 * i))
         begin
            rd_val = {16'h0, r_reg.winmap[i]};
         end
         if (reg_addr == FRF_OFF_SEGDESC + 8'(4 * i))
         begin
            rd_val = {16'h0, r_reg.segdesc[i]};
         end
      end
   end

   // Next state: bus side first, then the sequencer, so that hardware
   // updates win over a same-cycle software store or clear.
   always_comb
   begin
      r_next = r_reg;
      r_next.clock = r_reg.clock + 16'h0001;
      r_next.rdata = reg_rd ? rd_val : 32'h0;
      // Reading the function state acknowledges the interrupt.
      if (reg_rd && reg_addr == FRF_OFF_FUNC_STATE)
      begin
         r_next.irq = 1'b0;
      end
      // Plain stores; the bus never stalls, so any access may interleave.
      if (reg_wr)
      begin
         if (reg_addr == FRF_OFF_PROC_INDEX)
         begin
            r_next.proc_index = reg_wdata[15:0];
         end
         if (reg_addr == FRF_OFF_CONTROL)
         begin
            r_next.control[FRF_CTL_SUPPRESS_OK] = reg_wdata[0];
         end
         for (int i = 0; i < FRF_NUM_OPERANDS; i++)
         begin
            if (reg_addr == FRF_OFF_OPERAND + 8'(4 * i))
            begin
               r_next.operand[i] = reg_wdata[15:0];
            end
         end
         for (int i = 0; i < FRF_NUM_WINDOWS; i++)
         begin
            // Data windows store a map only; they never start work.
            if (reg_addr == FRF_OFF_WINMAP + 8'(4 * i))
            begin
               r_next.winmap[i] = reg_wdata[15:0];
            end
            if (reg_addr == FRF_OFF_SEGDESC + 8'(4 * i))
            begin
               r_next.segdesc[i] = reg_wdata[15:0];
            end
         end
      end
      unique case (r_reg.st)
         FRF_ST_IDLE:
         begin
            // An opcode written while busy is ignored: undefined anyway.
            if (reg_wr && reg_addr == FRF_OFF_OPCODE)
            begin
               r_next.opcode = reg_wdata[7:0];
               r_next.st = FRF_ST_QUALIFY;
               r_next.compl = FRF_CS_BUSY;
               r_next.win_busy = 1'b1;
               r_next.fault = 1'b0;
            end
         end
         FRF_ST_QUALIFY:
         begin
            if (r_reg.proc_index < 16'(NUM_PROCS) && !r_reg.proc_lock)
            begin
               r_next.proc_lock = 1'b1;
               r_next.st = FRF_ST_DECODE;
            end
            else
            begin
               r_next.fault = 1'b1;
               r_next.fault_code = FRF_FC_PROCESS;
               r_next.st = FRF_ST_FINISH;
            end
         end
         FRF_ST_DECODE:
         begin
            if (r_reg.opcode == 8'h00 || r_reg.opcode > FRF_OP_SET_MODE)
            begin
               r_next.fault = 1'b1;
               r_next.fault_code = FRF_FC_OPCODE;
               r_next.st = FRF_ST_FINISH;
            end
            else
            begin
               r_next.need = frf_operand_count(r_reg.opcode);
               r_next.fetch_idx = 3'h0;
               r_next.st = (frf_operand_count(r_reg.opcode) == 3'h0) ?
                  FRF_ST_OPERATE : FRF_ST_FETCH;
            end
         end
         FRF_ST_FETCH:
         begin
            // One operand per cycle, lowest slot first; field kept intact.
            r_next.work[r_reg.fetch_idx] =
               r_reg.operand[r_reg.fetch_idx];
            r_next.fetch_idx = r_reg.fetch_idx + 3'h1;
            if (r_reg.fetch_idx + 3'h1 == r_reg.need)
            begin
               r_next.st = FRF_ST_OPERATE;
            end
         end
         FRF_ST_OPERATE:
         begin
            r_next.st = FRF_ST_UPDATE;
            if (r_reg.opcode == FRF_OP_TEST_OBJECT)
            begin
               // Checks follow in order: type, rights, then bounds.
               if (!desc[FRF_SD_TYPE])
               begin
                  r_next.fault = 1'b1;
                  r_next.fault_code = FRF_FC_TYPE;
                  r_next.st = FRF_ST_FINISH;
               end
               else if (!desc[FRF_SD_RIGHT])
               begin
                  r_next.fault = 1'b1;
                  r_next.fault_code = FRF_FC_RIGHTS;
                  r_next.st = FRF_ST_FINISH;
               end
               else if (sel[15:2] >= desc[13:0])
               begin
                  r_next.fault = 1'b1;
                  r_next.fault_code = FRF_FC_BOUNDS;
                  r_next.st = FRF_ST_FINISH;
               end
            end
            else if (r_reg.opcode == FRF_OP_WINDOW_REMAP)
            begin
               // The control window is fixed unless in physical mode.
               if (r_reg.work[0] > 16'(FRF_CONTROL_WINDOW) ||
                   (r_reg.work[0] == 16'(FRF_CONTROL_WINDOW) &&
                    !r_reg.control[FRF_CTL_PHYSICAL]))
               begin
                  r_next.fault = 1'b1;
                  r_next.fault_code = FRF_FC_REMAP;
                  r_next.st = FRF_ST_FINISH;
               end
            end
         end
         FRF_ST_UPDATE:
         begin
            // Destination operands are the facility's own objects.
            r_next.st = FRF_ST_RESULT;
            if (r_reg.opcode == FRF_OP_WINDOW_REMAP)
            begin
               if (r_reg.work[0][2:0] == FRF_CONTROL_WINDOW)
               begin
                  r_next.win4map = r_reg.work[1];
               end
               else
               begin
                  r_next.winmap[r_reg.work[0][1:0]] = r_reg.work[1];
               end
            end
            else if (r_reg.opcode == FRF_OP_SET_MODE)
            begin
               r_next.control[FRF_CTL_PHYSICAL] = r_reg.work[0][0];
            end
         end
         FRF_ST_RESULT:
         begin
            // Functions without a return value leave the results alone.
            r_next.st = FRF_ST_FINISH;
            if (r_reg.opcode == FRF_OP_READ_STATUS)
            begin
               r_next.result = {r_reg.clock, 14'h0, r_reg.control};
            end
            else if (r_reg.opcode == FRF_OP_TEST_OBJECT)
            begin
               r_next.result[7:0] = FRF_BOOL_TRUE;
            end
         end
         FRF_ST_FINISH:
         begin
            r_next.st = FRF_ST_IDLE;
            r_next.compl = r_reg.fault ? FRF_CS_FAULT : FRF_CS_OK;
            r_next.win_busy = 1'b0;
            r_next.proc_lock = 1'b0;
            if (r_reg.fault)
            begin
               r_next.fault_info = {r_reg.opcode, r_reg.fault_code};
            end
            if (r_reg.fault || !r_reg.control[FRF_CTL_SUPPRESS_OK])
            begin
               r_next.irq = 1'b1;
            end
         end
      endcase
   end

   // Single register stage for the whole state.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   AST_OPCODE_STARTS: assert property (
      (r_reg.st == FRF_ST_IDLE && reg_wr && reg_addr == FRF_OFF_OPCODE)
      |=> (r_reg.st == FRF_ST_QUALIFY && r_reg.compl == FRF_CS_BUSY))
      else $error("Opcode write did not start execution.");
   AST_OTHER_WRITE_IDLE: assert property (
      (r_reg.st == FRF_ST_IDLE && reg_wr && reg_addr != FRF_OFF_OPCODE)
      |=> r_reg.st == FRF_ST_IDLE)
      else $error("Non-opcode write started a function.");
   AST_WINDOW_BUSY: assert property (
      r_reg.win_busy == (r_reg.st != FRF_ST_IDLE))
      else $error("Control window not shown in use.");
   AST_READY_STATE: assert property (
      (r_reg.compl == FRF_CS_BUSY) == (r_reg.st != FRF_ST_IDLE))
      else $error("Completion state disagrees with activity.");
   AST_QUALIFY_NEXT: assert property (
      r_reg.st == FRF_ST_QUALIFY
      |=> r_reg.st inside {FRF_ST_DECODE, FRF_ST_FINISH})
      else $error("Qualify step went astray.");

   AST_FAULT_IRQ: assert property (
      (r_reg.st == FRF_ST_FINISH && r_reg.fault)
      |=> irq_req && r_reg.compl == FRF_CS_FAULT)
      else $error("Faulted completion did not interrupt.");

   AST_SUPPRESS_OK: assert property (
      (r_reg.st == FRF_ST_FINISH && !r_reg.fault && !irq_req &&
       r_reg.control[FRF_CTL_SUPPRESS_OK]) |=> !irq_req)
      else $error("Suppressed success still interrupted.");

   AST_COMPLETE_OK: assert property (
      (r_reg.st == FRF_ST_FINISH && !r_reg.fault)
      |=> r_reg.compl == FRF_CS_OK && !r_reg.win_busy)
      else $error("Successful completion state wrong.");

   AST_FAULT_INFO: assert property (
      (r_reg.st == FRF_ST_FINISH && r_reg.fault)
      |=> r_reg.fault_info == {$past(r_reg.opcode), $past(r_reg.fault_code)})
      else $error("Fault information not recorded.");

   AST_WIN4_FIXED: assert property (
      (!r_reg.control[FRF_CTL_PHYSICAL] && r_reg.st == FRF_ST_UPDATE)
      |=> $stable(r_reg.win4map))
      else $error("Control window remapped in logical mode.");

   AST_BOOLEAN: assert property (
      (r_reg.st == FRF_ST_RESULT && r_reg.opcode == FRF_OP_TEST_OBJECT)
      |=> r_reg.result[7:0] == FRF_BOOL_TRUE)
      else $error("Boolean return value wrong.");

   AST_RESULT_KEPT: assert property (
      (r_reg.st == FRF_ST_UPDATE && r_reg.opcode == FRF_OP_SET_MODE)
      |=> ##1 $stable(r_reg.result))
      else $error("Result changed without a return value.");

   AST_DONE_BOUND: assert property (
      (r_reg.st == FRF_ST_DECODE) |-> ##[1:12] r_reg.st == FRF_ST_IDLE)
      else $error("Function did not finish in time.");

   COV_READ_STATUS: cover property (
      r_reg.st == FRF_ST_RESULT && r_reg.opcode == FRF_OP_READ_STATUS);
   COV_FAULT: cover property (r_reg.st == FRF_ST_FINISH && r_reg.fault);
   COV_REMAP: cover property (
      r_reg.st == FRF_ST_UPDATE && r_reg.opcode == FRF_OP_WINDOW_REMAP);
   COV_SUPPRESSED: cover property (r_reg.st == FRF_ST_FINISH &&
      !r_reg.fault && r_reg.control[FRF_CTL_SUPPRESS_OK]);

endmodule : frf_request_facility

// ==== verif/frf_ctrl_model.sv ====
// Purpose: Controller model that issues functions over the register port.
// Assumes: Called from the bench just after reset release, one caller.
// Notes: Released address and data show the inverse of their last value.
`timescale 1ns/1ps

module frf_ctrl_model
   import frf_pkg::*;
(
   input wire logic clk,
   input wire logic [FRF_DW-1:0] reg_rdata,
   input wire logic irq_req,
   output logic [FRF_AW-1:0] reg_addr,
   output logic [FRF_DW-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);

   // Idle bus at time zero.
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One write cycle; a gap cycle follows so strobes never collide.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // One read cycle; data is taken once the taking edge has settled.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd

   // Operands and process index go first, the opcode last, then we wait.
   task automatic issue(input logic [7:0] op, input logic [15:0] pidx,
      input logic [15:0] op0, input logic [15:0] op1,
      output logic [31:0] busy_st, output logic irq_seen,
      output logic [31:0] done_st);
      wr(FRF_OFF_OPERAND, {16'h0, op0});
      wr(FRF_OFF_OPERAND + 8'h04, {16'h0, op1});
      wr(FRF_OFF_PROC_INDEX, {16'h0, pidx});
      wr(FRF_OFF_OPCODE, {24'h0, op});
      rd(FRF_OFF_FUNC_STATE, busy_st);
      irq_seen = 1'b0;
      // Suppressed completions never interrupt, so the wait is bounded.
      for (int i = 0; i < 16 && !irq_seen; i++)
      begin
         @(posedge clk);
         #1;
         // An unknown request line ends the wait and fails the compare.
         irq_seen = irq_req;
      end
      rd(FRF_OFF_FUNC_STATE, done_st);
   endtask : issue

endmodule : frf_ctrl_model

// ==== verif/frf_request_facility_tb.sv ====
// Purpose: Self-checking bench for the function request facility.
// Assumes: The controller model drives the register port.
// Notes: A small process count keeps the process fault easy to reach.
`timescale 1ns/1ps

module frf_request_facility_tb
   import frf_pkg::*;
;

   localparam int PROCS = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [FRF_AW-1:0] reg_addr;
   logic [FRF_DW-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [FRF_DW-1:0] reg_rdata;
   logic irq_req;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] bs;
   logic [31:0] ds;
   logic [31:0] v;
   logic [31:0] w;
   logic irq_seen;

   frf_request_facility #(.NUM_PROCS(PROCS)) DUT (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req));

   frf_ctrl_model ctl (.clk(clk), .reg_rdata(reg_rdata), .irq_req(irq_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));

   // Clock of 4 ns period.
   always #2 clk = ~clk;

   // A hang is cut short well after the tests should have ended.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Reset state, unmapped read, and plain stores that must not start work.
   task automatic t_reset();
      ctl.rd(FRF_OFF_FUNC_STATE, v);
      chk("state", 32'h0, v);
      ctl.rd(FRF_OFF_CONTROL, v);
      chk("control", 32'h0, v);
      ctl.rd(8'hfc, v);
      chk("unmapped", 32'h0, v);
      ctl.wr(FRF_OFF_OPERAND, 32'h0055);
      ctl.wr(FRF_OFF_PROC_INDEX, 32'h0001);
      repeat (12) @(posedge clk);
      ctl.rd(FRF_OFF_FUNC_STATE, v);
      chk("idle state", 32'h0, v);
      ctl.rd(FRF_OFF_OPERAND, v);
      chk("operand", 32'h0055, v);
      chk("irq idle", 32'h0, {31'h0, irq_req});
      $display("test reset done");
   endtask : t_reset

   // A zero-operand function with a return value.
   task automatic t_status();
      ctl.issue(FRF_OP_READ_STATUS, 16'h0, 16'h0, 16'h0, bs, irq_seen, ds);
      chk("busy", 32'h11, {27'h0, bs[4:0]});
      chk("irq", 32'h1, {31'h0, irq_seen});
      chk("done", 32'h02, {27'h0, ds[4:0]});
      chk("irq ack", 32'h0, {31'h0, irq_req});
      ctl.rd(FRF_OFF_RESULT, v);
      chk("result", 32'h0, {16'h0, v[15:0]});
      $display("test status done");
   endtask : t_status

   // Opcode, process and remap faults each record their fault code.
   task automatic t_faults();
      logic [7:0] op [3] = '{8'h7f, FRF_OP_READ_STATUS, FRF_OP_WINDOW_REMAP};
      logic [15:0] px [3] = '{16'h0, 16'(PROCS), 16'h0};
      logic [7:0] fc [3] = '{FRF_FC_OPCODE, FRF_FC_PROCESS, FRF_FC_REMAP};
      for (int i = 0; i < 3; i++)
      begin
         ctl.issue(op[i], px[i], 16'h4, 16'h1234, bs, irq_seen, ds);
         chk("fault state", 32'h3, {30'h0, ds[1:0]});
         chk("fault irq", 32'h1, {31'h0, irq_seen});
         ctl.rd(FRF_OFF_FAULT_INFO, v);
         chk("fault info", {16'h0, op[i], fc[i]}, v);
      end
      ctl.rd(FRF_OFF_WIN4MAP, v);
      chk("window4 map", 32'h0, v);
      $display("test faults done");
   endtask : t_faults

   // Selector checks: pass, bounds at the limit, type, rights.
   task automatic t_object();
      logic [15:0] sel [4] = '{16'h000c, 16'h0010, 16'h0001, 16'h0002};
      logic [7:0] fc [4] = '{8'h00, FRF_FC_BOUNDS, FRF_FC_TYPE,
         FRF_FC_RIGHTS};
      ctl.wr(FRF_OFF_SEGDESC, 32'hc004);
      ctl.wr(FRF_OFF_SEGDESC + 8'h04, 32'h4004);
      ctl.wr(FRF_OFF_SEGDESC + 8'h08, 32'h8004);
      for (int i = 0; i < 4; i++)
      begin
         ctl.issue(FRF_OP_TEST_OBJECT, 16'h1, sel[i], 16'h0, bs, irq_seen, ds);
         if (fc[i] == 8'h00)
         begin
            chk("object ok", 32'h2, {30'h0, ds[1:0]});
            ctl.rd(FRF_OFF_RESULT, v);
            chk("boolean", 32'h1, {31'h0, v[0]});
         end
         else
         begin
            chk("object fault", 32'h3, {30'h0, ds[1:0]});
            ctl.rd(FRF_OFF_FAULT_INFO, v);
            chk("object code", {16'h0, FRF_OP_TEST_OBJECT, fc[i]}, v);
         end
      end
      $display("test object done");
   endtask : t_object

   // A function without return value leaves the result alone.
   task automatic t_remap();
      ctl.rd(FRF_OFF_RESULT, w);
      ctl.issue(FRF_OP_WINDOW_REMAP, 16'h2, 16'h1, 16'h1234, bs, irq_seen, ds);
      chk("remap state", 32'h2, {30'h0, ds[1:0]});
      ctl.rd(FRF_OFF_WINMAP + 8'h04, v);
      chk("window1 map", 32'h1234, v);
      ctl.rd(FRF_OFF_OPERAND + 8'h04, v);
      chk("operand kept", 32'h1234, v);
      ctl.rd(FRF_OFF_RESULT, v);
      chk("result kept", w, v);
      $display("test remap done");
   endtask : t_remap

   // Success interrupts suppressed, fault interrupts still delivered.
   task automatic t_suppress();
      ctl.wr(FRF_OFF_CONTROL, 32'h1);
      ctl.issue(FRF_OP_READ_STATUS, 16'h0, 16'h0, 16'h0, bs, irq_seen, ds);
      chk("quiet irq", 32'h0, {31'h0, irq_seen});
      chk("quiet state", 32'h2, {30'h0, ds[1:0]});
      ctl.rd(FRF_OFF_RESULT, v);
      chk("status ctl", 32'h1, {30'h0, v[1:0]});
      ctl.issue(8'hee, 16'h0, 16'h0, 16'h0, bs, irq_seen, ds);
      chk("fault irq on", 32'h1, {31'h0, irq_seen});
      ctl.wr(FRF_OFF_CONTROL, 32'h0);
      $display("test suppress done");
   endtask : t_suppress

   // Physical mode may remap the control window; mode bit is read-only.
   task automatic t_mode();
      ctl.issue(FRF_OP_SET_MODE, 16'h0, 16'h1, 16'h0, bs, irq_seen, ds);
      ctl.wr(FRF_OFF_CONTROL, 32'h0);
      ctl.rd(FRF_OFF_CONTROL, v);
      chk("mode", 32'h2, v);
      ctl.issue(FRF_OP_WINDOW_REMAP, 16'h0, 16'h4, 16'habcd, bs, irq_seen, ds);
      chk("remap4 state", 32'h2, {30'h0, ds[1:0]});
      ctl.rd(FRF_OFF_WIN4MAP, v);
      chk("window4 phys", 32'habcd, v);
      $display("test mode done");
   endtask : t_mode

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // Reset for five cycles, then the scenarios in turn.
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_status();
      t_faults();
      t_object();
      t_remap();
      t_suppress();
      t_mode();
      complete_run();
   end

endmodule : frf_request_facility_tb
